// >>> mode_seq_cfg.svh
`ifndef MODE_SEQ_CFG_SVH
`define MODE_SEQ_CFG_SVH
// What this block does
// RL1: Exactly one of four modes held.
// RL2: Halted mode never runs user program.
// RL3: Halting keeps timers, counters, flags, image.
// RL4: Halted mode asserts output inhibit.
// RL5: Halted to running calls unsupervised startup routine.
// RL6: Startup keeps output inhibit asserted.
// RL7: Run lamp blinks at least 3 s.
// RL8: Startup completion enters running mode.
// RL9: Running repeats main routine, alarms may insert.
// RL10: Running keeps timers active, refreshes image.
// RL11: Running releases output inhibit.
// RL12: Up to three breakpoints set by tool.
// RL13: Breakpoint pauses; step or resume.
// RL14: Paused: run lamp blinks, stop lamp on.
// RL15: Paused halts all code execution.
// RL16: Paused freezes timers, clock keeps counting.
// RL17: Paused asserts output inhibit.
// RL18: Paused keeps processor connections established.
// RL19: Refuse single step above two breakpoints.
// RL20: Breakpoints usable without test mode.
// RL21: Clear inputs, startup, then cycle phases.
// RL22: Halted: stop lamp; running: run lamp.

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS     4
// Cycles per ms taken first, so 3000 ms still fits in 32 bits
`define MIN_BLINK_MS      3000
`define MIN_BLINK_CYCLES  (`MIN_BLINK_MS * (1000000 / `CLK_PERIOD_NS))
`define BLINK_HALF_MS     250
`define BLINK_HALF_CYCLES ((`BLINK_HALF_MS * 1000000) / `CLK_PERIOD_NS)

// ****************************************
// Breakpoints
// ****************************************
`define BP_SLOTS          3
`define BP_STEP_MAX       2
`define BP_ADDR_W         16
`endif

// >>> mode_seq_pkg.sv
package mode_seq_pkg;
	typedef enum logic [1:0] {
		MODE_HALTED, MODE_STARTUP, MODE_RUNNING, MODE_PAUSED
	} op_mode_t;
	typedef enum logic [1:0] {
		PH_IDLE, PH_CLR_OUT, PH_READ_IN, PH_MAIN
	} cyc_phase_t;
endpackage : mode_seq_pkg

// >>> bp_if.sv
`timescale 1ns/100ps
`include "mode_seq_cfg.svh"
interface bp_if;
	logic                    set_stb;
	logic                    clr_stb;
	logic                    clr_all;
	logic [1:0]              slot;
	logic [`BP_ADDR_W-1:0]   addr;
	logic                    act;
	logic [`BP_ADDR_W-1:0]   pc;
	logic                    pc_vld;
	logic                    hit;
	logic [1:0]              count;
	modport owner (input set_stb, clr_stb, clr_all, slot, addr, act, pc,
		pc_vld, output hit, count);
	modport user  (output set_stb, clr_stb, clr_all, slot, addr, act, pc,
		pc_vld, input hit, count);
endinterface : bp_if

// >>> bp_table.sv
`timescale 1ns/100ps
`include "mode_seq_cfg.svh"
module bp_table (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Table access
	bp_if.owner      bp
);
	logic [`BP_ADDR_W-1:0] addr_q [`BP_SLOTS];
	logic [`BP_SLOTS-1:0]  def_q;
	logic [`BP_SLOTS-1:0]  act_q;
	logic [`BP_SLOTS-1:0]  match;
	logic                  hit_q;

	// ****************************************
	// Slots
	// ****************************************
	// Slot 3 is not a slot; writes to it are dropped
	genvar g;
	generate
		for (g = 0; g < `BP_SLOTS; g++) begin : g_slot
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					addr_q[g] <= '0;
					def_q[g]  <= 1'b0;
					act_q[g]  <= 1'b0;
				end else if (bp.clr_all) begin
					def_q[g] <= 1'b0;
					act_q[g] <= 1'b0;
				end else if (bp.slot == 2'(g) && bp.set_stb) begin // RL12
					addr_q[g] <= bp.addr;
					def_q[g]  <= 1'b1;
					act_q[g]  <= bp.act;
				end else if (bp.slot == 2'(g) && bp.clr_stb) begin // RL12
					def_q[g] <= 1'b0;
					act_q[g] <= 1'b0;
				end
			end
			assign match[g] = def_q[g] && act_q[g] && bp.pc_vld
				&& addr_q[g] == bp.pc;
		end
	endgenerate

	// Hit comes out of a register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			hit_q <= 1'b0;
		else
			hit_q <= |match;
	end

	assign bp.hit   = hit_q;
	assign bp.count = 2'({1'b0, def_q[0]} + {1'b0, def_q[1]}
		+ {1'b0, def_q[2]});
endmodule : bp_table

// >>> mode_sequencer.sv
`timescale 1ns/100ps
`include "mode_seq_cfg.svh"
module mode_sequencer
	import mode_seq_pkg::*;
#(
	parameter int unsigned BLINK_MIN = `MIN_BLINK_CYCLES,
	parameter int unsigned BLINK_HALF = `BLINK_HALF_CYCLES
) (
	// Clock and reset
	input  wire logic                  REF_CLK,
	input  wire logic                  RESET_N,
	// Mode requests
	input  wire logic                  RUN_REQ,
	input  wire logic                  STOP_REQ,
	input  wire logic                  FAULT,
	// Program engine
	input  wire logic                  STARTUP_DONE,
	input  wire logic                  CYCLE_DONE,
	input  wire logic                  PHASE_DONE,
	input  wire logic [`BP_ADDR_W-1:0] PC,
	input  wire logic                  PC_VALID,
	input  wire logic                  STMT_DONE,
	// Programming tool
	input  wire logic                  BP_SET,
	input  wire logic                  BP_CLEAR,
	input  wire logic                  BP_CLEAR_ALL,
	input  wire logic [1:0]            BP_SLOT,
	input  wire logic [`BP_ADDR_W-1:0] BP_ADDR,
	input  wire logic                  BP_ACTIVE,
	input  wire logic                  STEP_REQ,
	input  wire logic                  RESUME_REQ,
	// Engine control
	output logic                       PROGRAM_ENABLE,
	output logic                       STARTUP_CALL,
	output logic                       SUPERVISE_EN,
	output logic                       CLEAR_INPUT_IMAGE,
	output logic                       CLEAR_OUTPUT_IMAGE,
	output logic                       READ_INPUTS,
	output logic                       MAIN_CALL,
	output logic                       TIMERS_RUN,
	output logic                       RTC_RUN,
	output logic                       LINKS_KEEP,
	output logic                       STEP_GRANT,
	output logic                       STEP_REFUSED,
	// Process outputs and lamps
	output logic                       OUTPUT_INHIBIT,
	output logic                       ACTIVE_INDICATOR,
	output logic                       HALT_INDICATOR,
	// Status
	output logic [1:0]                 MODE,
	output logic [1:0]                 BP_COUNT
);
	op_mode_t   mode_q;
	cyc_phase_t phase_q;
	logic       clr_in_q;
	logic       startup_go_q;
	logic       stepping_q;
	logic       skip_q;
	logic       grant_q;
	logic       refuse_q;
	logic [31:0] blink_cnt_q;
	logic [31:0] half_cnt_q;
	logic       blink_q;
	logic       blinking;
	logic       step_ok;

	bp_if bp ();

	// ****************************************
	// Breakpoint table
	// ****************************************
	// Tool access works in every mode, no test mode needed
	assign bp.set_stb = BP_SET; // RL20
	assign bp.clr_stb = BP_CLEAR;
	assign bp.clr_all = BP_CLEAR_ALL;
	assign bp.slot    = BP_SLOT;
	assign bp.addr    = BP_ADDR;
	assign bp.act     = BP_ACTIVE;
	assign bp.pc      = PC;
	assign bp.pc_vld  = PC_VALID && mode_q == MODE_RUNNING;

	bp_table u_bp (
		.clk     (REF_CLK),
		.reset_n (RESET_N),
		.bp      (bp)
	);

	// Stepping needs at most two breakpoints
	assign step_ok = bp.count <= 2'(`BP_STEP_MAX); // RL19

	// ****************************************
	// Mode machine
	// ****************************************
	// One enum register, so exactly one mode at a time
	always_ff @(posedge REF_CLK or negedge RESET_N) begin // RL1
		if (!RESET_N) begin
			mode_q <= MODE_HALTED;
		end else begin
			unique case (mode_q)
				MODE_HALTED:
					if (RUN_REQ && !STOP_REQ)
						mode_q <= MODE_STARTUP; // RL5
				MODE_STARTUP:
					if (STOP_REQ || FAULT)
						mode_q <= MODE_HALTED;
					else if (STARTUP_DONE && !clr_in_q)
						mode_q <= MODE_RUNNING; // RL8
				MODE_RUNNING:
					if (STOP_REQ || FAULT)
						mode_q <= MODE_HALTED;
					else if (bp.hit && !skip_q)
						mode_q <= MODE_PAUSED; // RL13
					else if (stepping_q && STMT_DONE)
						mode_q <= MODE_PAUSED; // RL13
				MODE_PAUSED:
					if (STOP_REQ || FAULT)
						mode_q <= MODE_HALTED;
					else if (RESUME_REQ || (STEP_REQ && step_ok))
						mode_q <= MODE_RUNNING; // RL13
			endcase
		end
	end

	// Step grant and refusal pulses
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			stepping_q <= 1'b0;
			skip_q     <= 1'b0;
			grant_q    <= 1'b0;
			refuse_q   <= 1'b0;
		end else begin
			grant_q  <= mode_q == MODE_PAUSED && STEP_REQ && step_ok
				&& !RESUME_REQ;
			refuse_q <= mode_q == MODE_PAUSED && STEP_REQ && !step_ok; // RL19
			if (mode_q == MODE_PAUSED && (RESUME_REQ || STEP_REQ)) begin
				stepping_q <= !RESUME_REQ && step_ok;
				// Skip the breakpoint we are standing on
				skip_q     <= 1'b1;
			end else if (mode_q != MODE_RUNNING) begin
				stepping_q <= 1'b0;
				skip_q     <= 1'b0;
			end else if (PC_VALID && !bp.hit) begin
				skip_q <= 1'b0;
			end else if (stepping_q && STMT_DONE) begin
				stepping_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Startup sequence
	// ****************************************
	// Input image is cleared for one cycle before the startup call
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			clr_in_q     <= 1'b0;
			startup_go_q <= 1'b0;
		end else begin
			clr_in_q     <= mode_q == MODE_HALTED && RUN_REQ && !STOP_REQ; // RL21
			startup_go_q <= clr_in_q && mode_q == MODE_STARTUP; // RL21
		end
	end

	// ****************************************
	// Cycle phases
	// ****************************************
	// Clear outputs, read inputs, run main; repeats while running
	always_ff @(posedge REF_CLK or negedge RESET_N) begin // RL9
		if (!RESET_N) begin
			phase_q <= PH_IDLE;
		end else if (mode_q == MODE_HALTED || mode_q == MODE_STARTUP) begin
			phase_q <= PH_IDLE;
		end else if (mode_q == MODE_RUNNING) begin
			unique case (phase_q)
				PH_IDLE:    phase_q <= PH_CLR_OUT; // RL21
				PH_CLR_OUT: if (PHASE_DONE) phase_q <= PH_READ_IN;
				PH_READ_IN: if (PHASE_DONE) phase_q <= PH_MAIN; // RL10
				PH_MAIN:    if (CYCLE_DONE) phase_q <= PH_CLR_OUT;
			endcase
		end
		// Paused: phase is held so the level resumes where it stopped
	end

	// ****************************************
	// Blink control
	// ****************************************
	// Minimum blink survives an early end or a fault in startup
	always_ff @(posedge REF_CLK or negedge RESET_N) begin // RL7
		if (!RESET_N)
			blink_cnt_q <= '0;
		else if (startup_go_q)
			blink_cnt_q <= 32'(BLINK_MIN);
		else if (blink_cnt_q != '0)
			blink_cnt_q <= blink_cnt_q - 32'd1;
	end

	assign blinking = blink_cnt_q != '0 || mode_q == MODE_PAUSED;

	// Blink phase, restarted high whenever not blinking
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			half_cnt_q <= '0;
			blink_q    <= 1'b0;
		end else if (!blinking) begin
			half_cnt_q <= '0;
			blink_q    <= 1'b1;
		end else if (half_cnt_q >= 32'(BLINK_HALF - 1)) begin
			half_cnt_q <= '0;
			blink_q    <= !blink_q;
		end else begin
			half_cnt_q <= half_cnt_q + 32'd1;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Image clears come only in startup and running, so halting keeps timers and image
	always_comb begin
		PROGRAM_ENABLE     = mode_q == MODE_RUNNING; // RL2 RL15 RL3
		STARTUP_CALL       = startup_go_q; // RL5
		SUPERVISE_EN       = mode_q == MODE_RUNNING; // RL5
		CLEAR_INPUT_IMAGE  = clr_in_q; // RL21
		CLEAR_OUTPUT_IMAGE = mode_q == MODE_RUNNING && phase_q == PH_CLR_OUT;
		READ_INPUTS        = mode_q == MODE_RUNNING && phase_q == PH_READ_IN;
		MAIN_CALL          = mode_q == MODE_RUNNING && phase_q == PH_MAIN;
		TIMERS_RUN         = mode_q == MODE_RUNNING; // RL10 RL16
		RTC_RUN            = 1'b1; // RL16
		LINKS_KEEP         = 1'b1; // RL18
		STEP_GRANT         = grant_q;
		STEP_REFUSED       = refuse_q;
		OUTPUT_INHIBIT     = mode_q != MODE_RUNNING; // RL4 RL6 RL11 RL17
		MODE               = mode_q;
		BP_COUNT           = bp.count;
	end

	// Lamps: blink wins over steady state
	always_comb begin
		if (blinking)
			ACTIVE_INDICATOR = blink_q; // RL7 RL14
		else
			ACTIVE_INDICATOR = mode_q == MODE_RUNNING; // RL22
		HALT_INDICATOR = mode_q == MODE_HALTED || mode_q == MODE_PAUSED; // RL22 RL14
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence s_run_stop;
		mode_q == MODE_HALTED && RUN_REQ && !STOP_REQ;
	endsequence
	property p_startup_entry;
		@(posedge REF_CLK) disable iff (!RESET_N)
		s_run_stop |=> mode_q == MODE_STARTUP ##1 STARTUP_CALL || !RESET_N
			|| mode_q != MODE_STARTUP;
	endproperty
	a_startup_entry: assert property (p_startup_entry) // RL5
		else $error("startup not called after run request");
	property p_inhibit;
		@(posedge REF_CLK) disable iff (!RESET_N)
		OUTPUT_INHIBIT == (mode_q != MODE_RUNNING);
	endproperty
	a_inhibit: assert property (p_inhibit) // RL4
		else $error("output inhibit wrong for mode");
	property p_startup_inhibit;
		@(posedge REF_CLK) disable iff (!RESET_N)
		STARTUP_CALL || CLEAR_INPUT_IMAGE |-> OUTPUT_INHIBIT && !SUPERVISE_EN;
	endproperty
	a_startup_inhibit: assert property (p_startup_inhibit) // RL6
		else $error("outputs or supervision live during startup");
	property p_halt_noprog;
		@(posedge REF_CLK) disable iff (!RESET_N)
		mode_q == MODE_HALTED |-> !PROGRAM_ENABLE && !MAIN_CALL;
	endproperty
	a_halt_noprog: assert property (p_halt_noprog) // RL2
		else $error("program runs while halted");
	property p_blink_min;
		@(posedge REF_CLK) disable iff (!RESET_N)
		STARTUP_CALL |=> blinking [*8];
	endproperty
	a_blink_min: assert property (p_blink_min) // RL7
		else $error("blink ended too early");
	property p_pause_lamps;
		@(posedge REF_CLK) disable iff (!RESET_N)
		mode_q == MODE_PAUSED |-> HALT_INDICATOR && blinking && !TIMERS_RUN;
	endproperty
	a_pause_lamps: assert property (p_pause_lamps) // RL14
		else $error("paused lamps or timers wrong");
	property p_refuse;
		@(posedge REF_CLK) disable iff (!RESET_N)
		mode_q == MODE_PAUSED && STEP_REQ && !RESUME_REQ && !STOP_REQ
			&& !FAULT && bp.count == 2'd3 |=> mode_q == MODE_PAUSED
			&& STEP_REFUSED;
	endproperty
	a_refuse: assert property (p_refuse) // RL19
		else $error("single step not refused");
	property p_hit_pause;
		@(posedge REF_CLK) disable iff (!RESET_N)
		mode_q == MODE_RUNNING && bp.hit && !skip_q && !STOP_REQ && !FAULT
			|=> mode_q == MODE_PAUSED;
	endproperty
	a_hit_pause: assert property (p_hit_pause) // RL13
		else $error("breakpoint hit did not pause");
	property p_done_run;
		@(posedge REF_CLK) disable iff (!RESET_N)
		mode_q == MODE_STARTUP && STARTUP_DONE && !clr_in_q && !STOP_REQ
			&& !FAULT |=> mode_q == MODE_RUNNING ##1 CLEAR_OUTPUT_IMAGE
			|| mode_q != MODE_RUNNING;
	endproperty
	a_done_run: assert property (p_done_run) // RL8
		else $error("startup completion did not run");
	property p_run_lamps;
		@(posedge REF_CLK) disable iff (!RESET_N)
		mode_q == MODE_RUNNING && !blinking |-> ACTIVE_INDICATOR
			&& !HALT_INDICATOR;
	endproperty
	a_run_lamps: assert property (p_run_lamps) // RL22
		else $error("running lamps wrong");
endmodule : mode_sequencer

// >>> engine_model.sv
`timescale 1ns/100ps
// ****************************************
// Program engine stand-in
// ****************************************
module engine_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Sequencer commands
	input  wire logic        startup_call,
	input  wire logic        phase_lvl,
	input  wire logic        main_lvl,
	input  wire logic        prog_en,
	input  wire logic [7:0]  lat,
	// Engine answers
	output logic             startup_done,
	output logic             phase_done,
	output logic             cycle_done,
	output logic [15:0]      pc,
	output logic             pc_valid,
	output logic             stmt_done
);
	logic [7:0]  wait_q;
	logic [15:0] pc_q;
	logic        step_ok;

	// Startup routine lasts lat cycles, lat of one at least
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wait_q <= 8'h00;
			startup_done <= 1'b0;
		end else begin
			if (startup_call)
				wait_q <= lat;
			else if (wait_q != 8'h00)
				wait_q <= wait_q - 8'h01;
			startup_done <= (wait_q == 8'h01);
		end
	end

	// Phases end every other cycle; eight statements per cycle
	assign step_ok = main_lvl & prog_en;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pc_q <= 16'h0000;
			phase_done <= 1'b0;
			stmt_done <= 1'b0;
			cycle_done <= 1'b0;
		end else begin
			phase_done <= phase_lvl & prog_en & ~phase_done;
			stmt_done <= step_ok;
			cycle_done <= step_ok & (pc_q == 16'h0007);
			if (step_ok)
				pc_q <= (pc_q == 16'h0007) ? 16'h0000 : pc_q + 16'h0001;
		end
	end

	// Address is garbage while not valid, so a stale match cannot pass
	assign pc_valid = step_ok;
	assign pc = step_ok ? pc_q : ~pc_q;
endmodule : engine_model

// >>> tb_top.sv
`timescale 1ns/100ps
`include "mode_seq_cfg.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module tb_top
	import mode_seq_pkg::*;
;
	logic REF_CLK, RESET_N, bp_act, eng_up, eng_ph, eng_cd, eng_pv, eng_sd;
	logic STARTUP_CALL, CLEAR_INPUT_IMAGE, CLEAR_OUTPUT_IMAGE, READ_INPUTS;
	logic MAIN_CALL, PROGRAM_ENABLE, SUPERVISE_EN, TIMERS_RUN, RTC_RUN;
	logic LINKS_KEEP, STEP_GRANT, STEP_REFUSED, OUTPUT_INHIBIT;
	logic ACTIVE_INDICATOR, HALT_INDICATOR;
	logic [1:0]  MODE, BP_COUNT, bp_slot;
	logic [7:0]  req_q, lat;
	logic [15:0] bp_addr, eng_pc;
	int          error_cnt, checks, lo, i;

	// ****************************************
	// Clock, reset and design
	// ****************************************
	initial begin
		REF_CLK = 1'b0;
		forever #2 REF_CLK = ~REF_CLK;
	end
	mode_sequencer #(.BLINK_MIN(20), .BLINK_HALF(4)) u_dut (
		.REF_CLK(REF_CLK), .RESET_N(RESET_N), .RUN_REQ(req_q[0]),
		.STOP_REQ(req_q[1]), .FAULT(req_q[2]), .STARTUP_DONE(eng_up),
		.CYCLE_DONE(eng_cd), .PHASE_DONE(eng_ph), .PC(eng_pc),
		.PC_VALID(eng_pv), .STMT_DONE(eng_sd), .BP_SET(req_q[3]),
		.BP_CLEAR(req_q[4]), .BP_CLEAR_ALL(req_q[5]), .BP_SLOT(bp_slot),
		.BP_ADDR(bp_addr), .BP_ACTIVE(bp_act), .STEP_REQ(req_q[6]),
		.RESUME_REQ(req_q[7]), .PROGRAM_ENABLE(PROGRAM_ENABLE),
		.STARTUP_CALL(STARTUP_CALL), .SUPERVISE_EN(SUPERVISE_EN),
		.CLEAR_INPUT_IMAGE(CLEAR_INPUT_IMAGE),
		.CLEAR_OUTPUT_IMAGE(CLEAR_OUTPUT_IMAGE), .READ_INPUTS(READ_INPUTS),
		.MAIN_CALL(MAIN_CALL), .TIMERS_RUN(TIMERS_RUN), .RTC_RUN(RTC_RUN),
		.LINKS_KEEP(LINKS_KEEP), .STEP_GRANT(STEP_GRANT),
		.STEP_REFUSED(STEP_REFUSED), .OUTPUT_INHIBIT(OUTPUT_INHIBIT),
		.ACTIVE_INDICATOR(ACTIVE_INDICATOR), .HALT_INDICATOR(HALT_INDICATOR),
		.MODE(MODE), .BP_COUNT(BP_COUNT));
	engine_model u_eng (
		.clk(REF_CLK), .reset_n(RESET_N), .startup_call(STARTUP_CALL),
		.phase_lvl(CLEAR_OUTPUT_IMAGE | READ_INPUTS), .main_lvl(MAIN_CALL),
		.prog_en(PROGRAM_ENABLE), .lat(lat), .startup_done(eng_up),
		.phase_done(eng_ph), .cycle_done(eng_cd), .pc(eng_pc),
		.pc_valid(eng_pv), .stmt_done(eng_sd));

	// ****************************************
	// Shared tasks
	// ****************************************
	task stop_test;
		$display("error_cnt %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	task tick;
		@(posedge REF_CLK);
		#1;
	endtask : tick
	// Request bits: run, stop, fault, set, clear, clear all, step, resume
	task pulse(input logic [7:0] b, input logic [1:0] s,
		input logic [15:0] a);
		@(posedge REF_CLK);
		req_q <= b;
		bp_slot <= s;
		bp_addr <= a;
		@(posedge REF_CLK);
		req_q <= 8'h00;
		#1;
	endtask : pulse
	task wait_mode(input op_mode_t m);
		for (i = 0; i < 200 && MODE !== m; i++)
			tick();
		if (MODE !== m) begin
			error_cnt++;
			$display("unexpected at %0t: mode %h exp %h", $time, MODE, m);
			stop_test();
		end
	endtask : wait_mode
	// Lamp must blink: some low and some high cycles in the window
	task blink_chk(input int n);
		lo = 0;
		repeat (n) begin
			tick();
			lo += (ACTIVE_INDICATOR === 1'b0);
		end
		`CHK(lo > 0 && lo < n, 1'b1)
	endtask : blink_chk

	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		`CHK(MODE, MODE_HALTED)
		`CHK(PROGRAM_ENABLE, 1'b0)
		`CHK(OUTPUT_INHIBIT, 1'b1)
		`CHK({ACTIVE_INDICATOR, HALT_INDICATOR}, 2'b01)
	endtask : t_reset
	task t_start(input logic [7:0] l);
		logic ci;
		ci = 1'b0;
		lat <= l;
		pulse(8'h01, 2'b00, 16'h0000);
		for (i = 0; i < 10 && STARTUP_CALL !== 1'b1; i++) begin
			ci |= CLEAR_INPUT_IMAGE;
			tick();
		end
		`CHK(ci, 1'b1)
		`CHK(STARTUP_CALL, 1'b1)
		`CHK(MODE, MODE_STARTUP)
		`CHK(SUPERVISE_EN, 1'b0)
		`CHK(OUTPUT_INHIBIT, 1'b1)
		`CHK(HALT_INDICATOR, 1'b0)
		repeat (11) tick();
		blink_chk(8);
	endtask : t_start
	task t_running;
		`CHK(MODE, MODE_RUNNING)
		tick();
		`CHK({ACTIVE_INDICATOR, HALT_INDICATOR}, 2'b10)
		`CHK({OUTPUT_INHIBIT, TIMERS_RUN}, 2'b01)
		for (i = 0; i < 40 && CLEAR_OUTPUT_IMAGE !== 1'b1; i++)
			tick();
		`CHK(CLEAR_OUTPUT_IMAGE, 1'b1)
		while (CLEAR_OUTPUT_IMAGE === 1'b1 && i++ < 80)
			tick();
		`CHK(READ_INPUTS, 1'b1)
		while (READ_INPUTS === 1'b1 && i++ < 80)
			tick();
		`CHK({MAIN_CALL, PROGRAM_ENABLE}, 2'b11)
	endtask : t_running
	task t_stop;
		pulse(8'h02, 2'b00, 16'h0000);
		wait_mode(MODE_HALTED);
		`CHK({OUTPUT_INHIBIT, PROGRAM_ENABLE}, 2'b10)
		`CHK({CLEAR_INPUT_IMAGE, CLEAR_OUTPUT_IMAGE}, 2'b00)
		repeat (24) tick();
		`CHK({ACTIVE_INDICATOR, HALT_INDICATOR}, 2'b01)
	endtask : t_stop
	task t_fault;
		lat <= 8'h3C;
		pulse(8'h01, 2'b00, 16'h0000);
		wait_mode(MODE_STARTUP);
		pulse(8'h04, 2'b00, 16'h0000);
		wait_mode(MODE_HALTED);
		blink_chk(8);
		`CHK(OUTPUT_INHIBIT, 1'b1)
	endtask : t_fault
	task t_bp;
		logic g;
		pulse(8'h08, 2'b00, 16'h0003);
		`CHK(BP_COUNT, 2'h1)
		pulse(8'h08, 2'b01, 16'h0005);
		pulse(8'h08, 2'b11, 16'h0006);
		`CHK(BP_COUNT, 2'h2)
		t_start(8'h02);
		wait_mode(MODE_PAUSED);
		`CHK(HALT_INDICATOR, 1'b1)
		blink_chk(8);
		`CHK({PROGRAM_ENABLE, MAIN_CALL}, 2'b00)
		`CHK({TIMERS_RUN, RTC_RUN}, 2'b01)
		`CHK(OUTPUT_INHIBIT, 1'b1)
		`CHK(LINKS_KEEP, 1'b1)
		g = 1'b0;
		pulse(8'h40, 2'b00, 16'h0000);
		for (i = 0; i < 6; i++) begin
			g |= STEP_GRANT;
			tick();
		end
		`CHK(g, 1'b1)
		wait_mode(MODE_PAUSED);
		pulse(8'h80, 2'b00, 16'h0000);
		wait_mode(MODE_RUNNING);
		wait_mode(MODE_PAUSED);
		pulse(8'h08, 2'b10, 16'h0006);
		`CHK(BP_COUNT, 2'h3)
		g = 1'b0;
		pulse(8'h40, 2'b00, 16'h0000);
		for (i = 0; i < 4; i++) begin
			g |= STEP_REFUSED;
			tick();
		end
		`CHK({g, MODE}, {1'b1, MODE_PAUSED})
		pulse(8'h10, 2'b10, 16'h0000);
		`CHK(BP_COUNT, 2'h2)
		pulse(8'h20, 2'b00, 16'h0000);
		`CHK(BP_COUNT, 2'h0)
		pulse(8'h80, 2'b00, 16'h0000);
		wait_mode(MODE_RUNNING);
		repeat (30) tick();
		`CHK(MODE, MODE_RUNNING)
	endtask : t_bp

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		error_cnt = 0;
		checks = 0;
		RESET_N = 1'b0;
		req_q = 8'h00;
		bp_slot = 2'b00;
		bp_addr = 16'h0000;
		bp_act = 1'b1;
		lat = 8'h02;
		repeat (2) @(posedge REF_CLK);
		RESET_N <= 1'b1;
		tick();
		t_reset();
		t_start(8'h02);
		t_running();
		t_stop();
		t_fault();
		t_stop();
		t_bp();
		t_stop();
		stop_test();
	end
endmodule : tb_top
